// ---- common/shift_right_mq_cfg.svh ----
// Named constants of the shift-right unit: instruction fields, opcodes, register offsets.
// Assumes it is included by bare name; holds definitions only.
`ifndef SHIFT_RIGHT_MQ_CFG_SVH
`define SHIFT_RIGHT_MQ_CFG_SVH

// ==========================================================================
// Instruction word fields (big-endian bit 0 of the word is bit 31 here)
// ==========================================================================
`define SRMQ_PRI_HI 31
`define SRMQ_PRI_LO 26
`define SRMQ_SRC_HI 25
`define SRMQ_SRC_LO 21
`define SRMQ_DST_HI 20
`define SRMQ_DST_LO 16
`define SRMQ_CNT_HI 15
`define SRMQ_CNT_LO 11
`define SRMQ_XO_HI 10
`define SRMQ_XO_LO 1
`define SRMQ_RECORD_BIT 0
// Shift amount inside the count register (big-endian bits 27-31).
`define SRMQ_AMT_HI 4
`define SRMQ_AMT_LO 0

// ==========================================================================
// Opcodes
// ==========================================================================
`define SRMQ_PRIMARY_OP 6'h1F
`define SRMQ_XO_REG_MERGE 10'h2D9
`define SRMQ_XO_IMM_MASK 10'h2B8
`define SRMQ_XO_IMM_MERGE 10'h2F8

// ==========================================================================
// Word constants and condition field layout
// ==========================================================================
`define SRMQ_ZERO32 32'h0000_0000
`define SRMQ_ONES32 32'hFFFF_FFFF
`define SRMQ_WIDTH6 6'h20
`define SRMQ_COND_NEG 3
`define SRMQ_COND_POS 2
`define SRMQ_COND_ZERO 1
`define SRMQ_COND_SO 0

// ==========================================================================
// Register offsets (byte addresses, low eight address bits decoded)
// ==========================================================================
`define SRMQ_OFS_INSN 8'h00
`define SRMQ_OFS_SRC 8'h04
`define SRMQ_OFS_COUNT 8'h08
`define SRMQ_OFS_AUX 8'h0C
`define SRMQ_OFS_RESULT 8'h10
`define SRMQ_OFS_COND 8'h14
`define SRMQ_OFS_XSO 8'h18
`define SRMQ_OFS_STATUS 8'h1C
`define SRMQ_HTRANS_ACTIVE 1

`endif

// ---- common/shift_right_mq_pkg.sv ----
// Types shared by the shift-right unit and its datapath core.
// Assumes nothing of its surroundings.
package shift_right_mq_pkg;
  typedef logic [31:0] word_t;
  typedef logic [4:0] amount_t;
  typedef logic [3:0] cond_t;
  typedef enum logic [1:0] {OP_NONE, OP_REG_MERGE, OP_IMM_MASK, OP_IMM_MERGE} op_kind_t;
endpackage

// ---- common/shift_core_if.sv ----
// Signals between the unit's register side and its combinational datapath core.
// Assumes both ends sit in one clock domain; the core holds no state.
`timescale 1ns/1ps
interface shift_core_if;
  import shift_right_mq_pkg::*;
  word_t insn;
  word_t src_word;
  word_t count_word;
  word_t aux_word;
  op_kind_t op;
  amount_t amount;
  word_t rotated;
  word_t mask;
  word_t result;
  logic record;
  logic [4:0] dest_idx;
  modport core (input insn, src_word, count_word, aux_word,
                output op, amount, rotated, mask, result, record, dest_idx);
  modport user (output insn, src_word, count_word, aux_word,
                input op, amount, rotated, mask, result, record, dest_idx);
endinterface

// ---- verilog/shift_merge_core.sv ----
// Combinational decode, rotate, mask and merge for the three shift-right forms.
// Assumes the caller registers every result it keeps.
`timescale 1ns/1ps
`include "shift_right_mq_cfg.svh"
module shift_merge_core (
  shift_core_if.core cif // Operands in, decoded results out.
);
  import shift_right_mq_pkg::*;

  // ========================================================================
  // Decode and shift
  // ========================================================================
  always_comb begin
    cif.record = cif.insn[`SRMQ_RECORD_BIT];
    cif.dest_idx = cif.insn[`SRMQ_DST_HI:`SRMQ_DST_LO];
    cif.op = OP_NONE;
    if (cif.insn[`SRMQ_PRI_HI:`SRMQ_PRI_LO] == `SRMQ_PRIMARY_OP) begin
      unique case (cif.insn[`SRMQ_XO_HI:`SRMQ_XO_LO])
        `SRMQ_XO_REG_MERGE: cif.op = OP_REG_MERGE;
        `SRMQ_XO_IMM_MASK: cif.op = OP_IMM_MASK;
        `SRMQ_XO_IMM_MERGE: cif.op = OP_IMM_MERGE;
        default: cif.op = OP_NONE;
      endcase
    end
    if (cif.op == OP_REG_MERGE) begin
      cif.amount = cif.count_word[`SRMQ_AMT_HI:`SRMQ_AMT_LO];
    end else begin
      cif.amount = cif.insn[`SRMQ_CNT_HI:`SRMQ_CNT_LO];
    end
    // A left rotation by 32 - N; at N = 0 the left shift by 32 yields zero, as wanted.
    cif.rotated = (cif.src_word >> cif.amount) |
                  (cif.src_word << (`SRMQ_WIDTH6 - {1'b0, cif.amount}));
    cif.mask = `SRMQ_ONES32 >> cif.amount;
    unique case (cif.op)
      OP_IMM_MASK: cif.result = cif.rotated & cif.mask;
      OP_REG_MERGE, OP_IMM_MERGE: begin
        cif.result = (cif.rotated & cif.mask) | (cif.aux_word & ~cif.mask);
      end
      OP_NONE: cif.result = `SRMQ_ZERO32;
    endcase
  end
endmodule

// ---- verilog/shift_right_mq_merge_unit.sv ----
// Shift-right unit with the auxiliary multiply-quotient register, as an AHB-Lite slave.
// Assumes a single AHB-Lite master issuing single word transfers; hready_in is hreadyout.
//
// What this block does
// - Instruction words split into primary opcode, source, dest, count, extended opcode.
// - Extended opcodes 729, 696 and 760 under primary 31 select the three shift forms.
// - The register merge form takes N from the low five bits of the count operand.
// - The source word is rotated left by 32 minus N, the same as right by N.
// - Mask is N zeros then ones; merging picks rotated bits at ones, auxiliary bits at zeros.
// - Register merge stores the rotated word as auxiliary and the merged word as result.
// - Immediate merge merges with the prior auxiliary value and stores the rotated word.
// - No form changes the exception register, summary overflow included.
// - With the record bit set the condition field follows the result, else it is kept.
`timescale 1ns/1ps
`include "shift_right_mq_cfg.svh"
module shift_right_mq_merge_unit (
  input wire logic mclk_in, // 125 MHz clock.
  input wire logic rstn_in, // Synchronous reset, active low.
  input wire logic hsel_in, // Slave select.
  input wire shift_right_mq_pkg::word_t haddr_in, // Byte address.
  input wire logic [1:0] htrans_in, // Transfer type.
  input wire logic hwrite_in, // Write when high.
  input wire logic [2:0] hsize_in, // Transfer size, word only.
  input wire shift_right_mq_pkg::word_t hwdata_in, // Write data.
  input wire logic hready_in, // Bus ready.
  output logic hreadyout_out, // Slave ready, registered.
  output logic hresp_out, // Always OKAY, registered.
  output shift_right_mq_pkg::word_t hrdata_out // Read data, registered.
);
  import shift_right_mq_pkg::*;

  // ========================================================================
  // Bus slave
  // ========================================================================
  logic wr_pend_reg, wr_pend_next;
  logic rd_pend_reg, rd_pend_next;
  logic [7:0] addr_reg, addr_next;
  logic ready_reg, ready_next;
  word_t rdata_reg, rdata_next;
  logic resp_reg, resp_next;
  logic take;
  logic exec_fire;
  word_t src_reg, src_next;
  word_t count_reg, count_next;
  word_t aux_reg, aux_next;
  word_t insn_reg, insn_next;
  word_t result_reg, result_next;
  cond_t cond_reg, cond_next;
  logic so_reg, so_next;
  logic illegal_reg, illegal_next;
  logic done_reg, done_next;
  logic [4:0] dest_reg, dest_next;
  shift_core_if cif ();

  assign take = hsel_in && htrans_in[`SRMQ_HTRANS_ACTIVE] && hready_in;
  // Writing the instruction word executes it in the same data phase.
  assign exec_fire = wr_pend_reg && (addr_reg == `SRMQ_OFS_INSN);

  // Reads take one wait state so the answer always reflects every earlier write.
  always_comb begin
    wr_pend_next = wr_pend_reg;
    rd_pend_next = rd_pend_reg;
    addr_next = addr_reg;
    ready_next = ready_reg;
    rdata_next = rdata_reg;
    // Only OKAY is ever answered.
    resp_next = 1'b0;
    if (rd_pend_reg) begin
      rd_pend_next = 1'b0;
      ready_next = 1'b1;
      unique case (addr_reg)
        `SRMQ_OFS_INSN: rdata_next = insn_reg;
        `SRMQ_OFS_SRC: rdata_next = src_reg;
        `SRMQ_OFS_COUNT: rdata_next = count_reg;
        `SRMQ_OFS_AUX: rdata_next = aux_reg;
        `SRMQ_OFS_RESULT: rdata_next = result_reg;
        `SRMQ_OFS_COND: rdata_next = {28'h000_0000, cond_reg};
        `SRMQ_OFS_XSO: rdata_next = {31'h0000_0000, so_reg};
        `SRMQ_OFS_STATUS: rdata_next = {19'h0_0000, dest_reg, 6'h00, illegal_reg, done_reg};
        default: rdata_next = `SRMQ_ZERO32;
      endcase
    end else if (hready_in) begin
      wr_pend_next = take && hwrite_in;
      rd_pend_next = take && !hwrite_in;
      if (take) begin
        addr_next = haddr_in[7:0];
        ready_next = hwrite_in;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      ready_reg <= 1'b1;
      rdata_reg <= `SRMQ_ZERO32;
      resp_reg <= 1'b0;
    end else begin
      wr_pend_reg <= wr_pend_next;
      rd_pend_reg <= rd_pend_next;
      addr_reg <= addr_next;
      ready_reg <= ready_next;
      rdata_reg <= rdata_next;
      resp_reg <= resp_next;
    end
  end

  assign hreadyout_out = ready_reg;
  assign hrdata_out = rdata_reg;
  assign hresp_out = resp_reg;

  // ========================================================================
  // Datapath registers
  // ========================================================================
  assign cif.insn = hwdata_in;
  assign cif.src_word = src_reg;
  assign cif.count_word = count_reg;
  assign cif.aux_word = aux_reg;

  shift_merge_core u_core (
    .cif(cif)
  );

  always_comb begin
    src_next = src_reg;
    count_next = count_reg;
    aux_next = aux_reg;
    insn_next = insn_reg;
    result_next = result_reg;
    cond_next = cond_reg;
    so_next = so_reg;
    illegal_next = illegal_reg;
    done_next = done_reg;
    dest_next = dest_reg;
    if (wr_pend_reg) begin
      unique case (addr_reg)
        `SRMQ_OFS_SRC: src_next = hwdata_in;
        `SRMQ_OFS_COUNT: count_next = hwdata_in;
        `SRMQ_OFS_AUX: aux_next = hwdata_in;
        `SRMQ_OFS_XSO: so_next = hwdata_in[0];
        default: ;
      endcase
    end
    if (exec_fire) begin
      insn_next = hwdata_in;
      illegal_next = (cif.op == OP_NONE);
      done_next = (cif.op != OP_NONE);
      if (cif.op != OP_NONE) begin
        // All three forms store the rotated word in the auxiliary register.
        aux_next = cif.rotated;
        result_next = cif.result;
        dest_next = cif.dest_idx;
        if (cif.record) begin
          cond_next[`SRMQ_COND_NEG] = cif.result[31];
          cond_next[`SRMQ_COND_POS] = !cif.result[31] && (cif.result != `SRMQ_ZERO32);
          cond_next[`SRMQ_COND_ZERO] = (cif.result == `SRMQ_ZERO32);
          cond_next[`SRMQ_COND_SO] = so_reg;
        end
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      src_reg <= `SRMQ_ZERO32;
      count_reg <= `SRMQ_ZERO32;
      aux_reg <= `SRMQ_ZERO32;
      insn_reg <= `SRMQ_ZERO32;
      result_reg <= `SRMQ_ZERO32;
      cond_reg <= 4'h0;
      so_reg <= 1'b0;
      illegal_reg <= 1'b0;
      done_reg <= 1'b0;
      dest_reg <= 5'h00;
    end else begin
      src_reg <= src_next;
      count_reg <= count_next;
      aux_reg <= aux_next;
      insn_reg <= insn_next;
      result_reg <= result_next;
      cond_reg <= cond_next;
      so_reg <= so_next;
      illegal_reg <= illegal_next;
      done_reg <= done_next;
      dest_reg <= dest_next;
    end
  end

  // ========================================================================
  // Assertions
  // ========================================================================
  logic ok_fire;
  assign ok_fire = exec_fire && (cif.op != OP_NONE);

  property p_decode_reject;
    @(posedge mclk_in) disable iff (!rstn_in)
    exec_fire && (hwdata_in[`SRMQ_PRI_HI:`SRMQ_PRI_LO] != `SRMQ_PRIMARY_OP)
      |=> illegal_reg && !done_reg && $stable(aux_reg) && $stable(result_reg);
  endproperty
  a_decode_reject: assert property (p_decode_reject)
    else $error("bad primary opcode executed");

  property p_xo_accept;
    @(posedge mclk_in) disable iff (!rstn_in)
    exec_fire && (hwdata_in[`SRMQ_PRI_HI:`SRMQ_PRI_LO] == `SRMQ_PRIMARY_OP) &&
      (hwdata_in[`SRMQ_XO_HI:`SRMQ_XO_LO] == `SRMQ_XO_IMM_MERGE)
      |=> done_reg && (dest_reg == $past(hwdata_in[`SRMQ_DST_HI:`SRMQ_DST_LO]));
  endproperty
  a_xo_accept: assert property (p_xo_accept)
    else $error("valid opcode not taken");

  property p_reg_count_merge;
    @(posedge mclk_in) disable iff (!rstn_in)
    exec_fire && (cif.op == OP_REG_MERGE)
      |=> ((result_reg ^ $past(aux_reg)) & ~(`SRMQ_ONES32 >> $past(count_reg[4:0]))) == 0 &&
          ((result_reg ^ aux_reg) & (`SRMQ_ONES32 >> $past(count_reg[4:0]))) == 0;
  endproperty
  a_reg_count_merge: assert property (p_reg_count_merge)
    else $error("register merge wrong");

  property p_rotate;
    @(posedge mclk_in) disable iff (!rstn_in)
    ok_fire |=> aux_reg == 32'({$past(src_reg), $past(src_reg)} >> $past(cif.amount));
  endproperty
  a_rotate: assert property (p_rotate)
    else $error("rotated word wrong");

  property p_imm_mask;
    @(posedge mclk_in) disable iff (!rstn_in)
    exec_fire && (cif.op == OP_IMM_MASK)
      |=> result_reg ==
          (aux_reg & (`SRMQ_ONES32 >> $past(hwdata_in[`SRMQ_CNT_HI:`SRMQ_CNT_LO])));
  endproperty
  a_imm_mask: assert property (p_imm_mask)
    else $error("immediate mask result wrong");

  property p_imm_merge;
    @(posedge mclk_in) disable iff (!rstn_in)
    exec_fire && (cif.op == OP_IMM_MERGE)
      |=> ((result_reg ^ $past(aux_reg)) &
           ~(`SRMQ_ONES32 >> $past(hwdata_in[`SRMQ_CNT_HI:`SRMQ_CNT_LO]))) == 0;
  endproperty
  a_imm_merge: assert property (p_imm_merge)
    else $error("immediate merge wrong");

  property p_so_kept;
    @(posedge mclk_in) disable iff (!rstn_in)
    exec_fire |=> $stable(so_reg);
  endproperty
  a_so_kept: assert property (p_so_kept)
    else $error("exception bit changed");

  property p_no_record;
    @(posedge mclk_in) disable iff (!rstn_in)
    exec_fire && !hwdata_in[`SRMQ_RECORD_BIT] |=> $stable(cond_reg);
  endproperty
  a_no_record: assert property (p_no_record)
    else $error("condition field changed");

  property p_cond_flags;
    @(posedge mclk_in) disable iff (!rstn_in)
    ok_fire && hwdata_in[`SRMQ_RECORD_BIT]
      |=> cond_reg[`SRMQ_COND_NEG] == result_reg[31] &&
          cond_reg[`SRMQ_COND_ZERO] == (result_reg == `SRMQ_ZERO32) &&
          cond_reg[`SRMQ_COND_POS] == ($signed(result_reg) > 0) &&
          cond_reg[`SRMQ_COND_SO] == $past(so_reg);
  endproperty
  a_cond_flags: assert property (p_cond_flags)
    else $error("condition flags wrong");
endmodule

// ---- verif/ahb_lite_master.sv ----
// AHB-Lite master model that issues single word transfers to the shift-right unit.
// Assumes every call of xfer starts just after a rising edge of mclk_in.
`timescale 1ns/1ps
module ahb_lite_master (
  input wire logic mclk_in, // Bus clock.
  input wire logic hready_in, // Bus ready from the slave.
  input wire shift_right_mq_pkg::word_t hrdata_in, // Read data from the slave.
  output logic hsel_out, // Slave select.
  output shift_right_mq_pkg::word_t haddr_out, // Byte address.
  output logic [1:0] htrans_out, // Transfer type.
  output logic hwrite_out, // Write when high.
  output logic [2:0] hsize_out, // Always a whole word.
  output shift_right_mq_pkg::word_t hwdata_out // Write data.
);
  import shift_right_mq_pkg::*;

  initial begin
    hsel_out = 1'b0;
    haddr_out = 32'h0000_0000;
    htrans_out = 2'h0;
    hwrite_out = 1'b0;
    hsize_out = 3'h2;
    hwdata_out = 32'h0000_0000;
  end

  // Nothing is released at the end, so a following call may drive at the same edge.
  task automatic xfer(input logic wr, input word_t addr, input word_t wdata, output word_t rdata);
    hsel_out <= 1'b1;
    haddr_out <= addr;
    htrans_out <= 2'h2;
    hwrite_out <= wr;
    hsize_out <= 3'h2;
    do @(posedge mclk_in); while (hready_in !== 1'b1);
    htrans_out <= 2'h0;
    // A read leaves the write bus toggling so stale data is never mistaken for valid.
    hwdata_out <= wr ? wdata : ~hwdata_out;
    do @(posedge mclk_in); while (hready_in !== 1'b1);
    rdata = hrdata_in;
  endtask
endmodule

// ---- verif/shift_right_mq_merge_unit_bench.sv ----
// Self-checking bench for the shift-right unit, compared with a model at every read.
// Assumes the unit answers as a zero-wait writer and a one-wait reader on AHB-Lite.
`timescale 1ns/1ps
`include "shift_right_mq_cfg.svh"
module shift_right_mq_merge_unit_bench;
  import shift_right_mq_pkg::*;
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic hsel, hwrite, hready, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  word_t haddr, hwdata, hrdata;
  word_t aux_m = 32'h0, res_m = 32'h0, cond_m = 32'h0;
  int seed = 52722;
  integer err_total = 0;
  integer comparisons = 0;

  always #4 mclk_in = ~mclk_in;

  shift_right_mq_merge_unit shift_right_mq_merge_unit_inst (.mclk_in(mclk_in),
    .rstn_in(rstn_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
    .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata));

  ahb_lite_master ahb_lite_master_inst (.mclk_in(mclk_in), .hready_in(hready),
    .hrdata_in(hrdata), .hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans),
    .hwrite_out(hwrite), .hsize_out(hsize), .hwdata_out(hwdata));

  // ==========================================================================
  // Checking and bus tasks
  // ==========================================================================
  task automatic results;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input word_t got, input word_t exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input word_t d);
    word_t r;
    ahb_lite_master_inst.xfer(1'b1, {24'h0, a}, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input word_t e);
    word_t r;
    ahb_lite_master_inst.xfer(1'b0, {24'h0, a}, 32'h0, r);
    chk(r, e);
  endtask

  // ==========================================================================
  // One execution: k 0 register merge, 1 immediate mask, 2 immediate merge
  // ==========================================================================
  task automatic run_op(input int k, input logic [4:0] n, input logic rec);
    word_t src, cnt, aux_w, ins, rot, msk;
    logic [4:0] idx, dst;
    logic [9:0] xo;
    logic xso;
    src = $random(seed);
    cnt = $random(seed);
    aux_w = $random(seed);
    idx = 5'($random(seed));
    dst = 5'($random(seed));
    xso = 1'($random(seed));
    xo = (k == 0) ? `SRMQ_XO_REG_MERGE : (k == 1) ? `SRMQ_XO_IMM_MASK : `SRMQ_XO_IMM_MERGE;
    cnt[4:0] = (k == 0) ? n : ~n;
    // The unused amount source always disagrees, so a wrong pick shows up.
    ins = {`SRMQ_PRIMARY_OP, idx, dst, (k == 0) ? ~n : n, xo, rec};
    wr(`SRMQ_OFS_SRC, src);
    wr(`SRMQ_OFS_COUNT, cnt);
    wr(`SRMQ_OFS_AUX, aux_w);
    wr(`SRMQ_OFS_XSO, {31'h0, xso});
    wr(`SRMQ_OFS_INSN, ins);
    rot = 32'({src, src} >> n);
    msk = 32'hFFFF_FFFF >> n;
    res_m = (k == 1) ? (rot & msk) : ((rot & msk) | (aux_w & ~msk));
    aux_m = rot;
    if (rec) begin
      cond_m = {28'h0, $signed(res_m) < 0, $signed(res_m) > 0, res_m == 0, xso};
    end
    rd(`SRMQ_OFS_RESULT, res_m);
    rd(`SRMQ_OFS_AUX, aux_m);
    rd(`SRMQ_OFS_COND, cond_m);
    rd(`SRMQ_OFS_XSO, {31'h0, xso});
    rd(`SRMQ_OFS_STATUS, {19'h0, dst, 8'h01});
    rd(`SRMQ_OFS_INSN, ins);
  endtask

  task automatic illegal(input word_t ins);
    word_t r;
    wr(`SRMQ_OFS_INSN, ins);
    rd(`SRMQ_OFS_RESULT, res_m);
    rd(`SRMQ_OFS_AUX, aux_m);
    ahb_lite_master_inst.xfer(1'b0, {24'h0, `SRMQ_OFS_STATUS}, 32'h0, r);
    chk({31'h0, r[1]}, 32'h1);
    chk({31'h0, r[0]}, 32'h0);
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    logic [4:0] nv [4];
    word_t t;
    nv = '{5'h00, 5'h1F, 5'h01, 5'h10};
    repeat (8) @(posedge mclk_in);
    rstn_in <= 1'b1;
    @(posedge mclk_in);
    for (int a = 0; a < 9; a++) begin
      rd(8'(a * 4), 32'h0);
    end
    for (int k = 0; k < 3; k++) begin
      for (int r = 0; r < 2; r++) begin
        for (int i = 0; i < 4; i++) begin
          run_op(k, nv[i], r[0]);
        end
      end
    end
    repeat (24) begin
      t = $random(seed);
      run_op(int'(t[1:0]) % 3, t[8:4], t[9]);
    end
    illegal({6'h1E, 10'h0A5, 5'h03, `SRMQ_XO_REG_MERGE, 1'b1});
    illegal({`SRMQ_PRIMARY_OP, 15'h1234, 10'h299, 1'b1});
    t = $random(seed);
    wr(`SRMQ_OFS_RESULT, t);
    rd(`SRMQ_OFS_RESULT, res_m);
    wr(8'h24, t);
    rd(8'h24, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    results();
  end

  initial begin
    #(60000 * 8);
    err_total++;
    results();
  end
endmodule
